// *** sbf_buf2.sv ***
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module sbf_buf2
  import sbf_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  logic [WIDTH-1:0] store [0:1];
  logic             wr_ptr;
  logic             rd_ptr;
  logic [1:0]       count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o  = store[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      store[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      case ({push, pop})
        2'b10:   count <= count + 2'h1;
        2'b01:   count <= count - 2'h1;
        default: count <= count;
      endcase
    end
  end

endmodule // sbf_buf2

// *** sbf_defs.svh ***
// Offsets, field positions, reset values and timing counts of the block.
// Assumes an 8-bit register port with byte-index addresses.
//
// What this block does
// - Serial clock divisor spans 2 to 2048 over all 64 field combinations.
// - Divisor equals (prescale field + 1) times two to (rate select + 1).
// - Serial bit rate is bus clock divided by the selected divisor.
// - Receive-complete flag, status bit 7, sets when received data lands.
// - Transmit-empty flag, status bit 5, shows empty data register; resets one.
// - Mode-fault flag, bit 4, sets on low select while master and enabled.
// - Mode fault clears after flagged status read then first control write.
// - Status readable anytime, writes ignored, bits 6 and 3..0 read zero.
// - Receive flag clears by flagged status read then low data byte read.
// - Transmit flag clears by flagged status read then low byte write.
`ifndef SBF_DEFS_SVH
`define SBF_DEFS_SVH

// --------------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------------
`define SBF_OFS_CTRL1      3'h0
`define SBF_OFS_CTRL2      3'h1
`define SBF_OFS_BAUD       3'h2
`define SBF_OFS_FLAGS      3'h3
`define SBF_OFS_DATA_HIGH  3'h4
`define SBF_OFS_DATA_LOW   3'h5

// --------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------
`define SBF_CTRL1_ENABLE   6
`define SBF_CTRL1_MASTER   4
`define SBF_CTRL2_MFDEN    4
`define SBF_FLAG_RX        7
`define SBF_FLAG_TX        5
`define SBF_FLAG_MF        4
`define SBF_BAUD_PRE_LSB   4
`define SBF_BAUD_SEL_LSB   0

// --------------------------------------------------------------------
// Reset values and timing
// --------------------------------------------------------------------
`define SBF_RST_CTRL1      8'h00
`define SBF_RST_CTRL2      8'h00
`define SBF_RST_BAUD       8'h00
`define SBF_RST_TX_EMPTY   1'b1
`define SBF_BITS           3'h7
`define SBF_CLK_PERIOD_NS  25

`endif

// *** sbf_pkg.sv ***
// Types shared by the serial rate and flag logic.
// Assumes the constants header is included by the files that need numbers.
package sbf_pkg;

  typedef enum logic [1:0] {
    SBF_IDLE  = 2'b01,
    SBF_SHIFT = 2'b10
  } sbf_state_t;

  typedef struct packed {
    logic [2:0] prescale;
    logic [2:0] rate_sel;
  } sbf_baud_t;

  typedef struct packed {
    logic rx_done;
    logic tx_empty;
    logic mode_fault;
  } sbf_flags_t;

endpackage : sbf_pkg

// *** sbf_slave_model.sv ***
// Behavioural serial peripheral on the far side of the link.
// Assumes sck idles low, data sampled by the master on sck rising.
`timescale 1ns/1ps
module sbf_slave_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // Serial link
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  output logic            miso_o,
  // Bench side
  input  wire logic [7:0] reply_i,
  output logic [7:0]      got_o,
  output logic [7:0]      frames_o
);
  logic       prev_sck;
  logic [2:0] cnt;
  logic [7:0] tx;
  logic [7:0] rx;

  // --------------------------------------------------------------------
  // Shifting
  // --------------------------------------------------------------------
  // Next bit is put out right after the master has sampled, MSB first;
  // spent bits are refilled with a changing pattern, never a stale copy.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      prev_sck <= 1'b0;
      cnt      <= 3'h0;
      tx       <= reply_i;
      rx       <= 8'h00;
      got_o    <= 8'h00;
      frames_o <= 8'h00;
    end else begin
      prev_sck <= sck_i;
      if (sck_i && !prev_sck) begin
        rx  <= {rx[6:0], mosi_i};
        cnt <= cnt + 3'h1;
        if (cnt == 3'h7) begin
          got_o    <= {rx[6:0], mosi_i};
          frames_o <= frames_o + 8'h01;
          tx       <= reply_i;
        end else begin
          tx <= {tx[6:0], ~tx[7]};
        end
      end
    end
  end

  assign miso_o = tx[7];
endmodule // sbf_slave_model

// *** sbf_top.sv ***
// Serial clock rate generator, status flags and a minimal master shifter.
// Assumes an 8-bit register port and pins synchronous to clk_i.
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "sbf_defs.svh"
module sbf_top
  import sbf_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // Register port
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [7:0]      rdata_o,
  // Serial link
  input  wire logic       ss_b_i,
  input  wire logic       miso_i,
  output logic            sck_o,
  output logic            mosi_o
);

  // ------------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------------
  function automatic logic hit(input logic strobe, input logic [2:0] a,
                               input logic [2:0] ofs);
    hit = strobe && (a == ofs);
  endfunction

  // Half serial period in bus cycles: (pre + 1) << sel
  function automatic logic [10:0] half_of(input sbf_baud_t b);
    half_of = 11'({8'h00, b.prescale} + 11'h001) << b.rate_sel;
  endfunction

  logic [7:0]  ctrl1, ctrl2, data_high, rx_data, shreg, buf_data;
  sbf_baud_t   baud;
  sbf_flags_t  flags;
  sbf_state_t  state;
  logic [10:0] half, half_cnt;
  logic [2:0]  bit_cnt;
  logic        rx_arm, tx_arm, mf_arm, sample, sck_q, toggle, done;
  logic        abort, is_master, rx_set, tx_push, mf_set;
  logic        buf_ready, buf_valid, buf_pop;
  logic        status_rd, low_rd, low_wr, ctrl1_wr, baud_wr;

  assign status_rd = hit(rd_i, addr_i, `SBF_OFS_FLAGS);
  assign low_rd    = hit(rd_i, addr_i, `SBF_OFS_DATA_LOW);
  assign low_wr    = hit(wr_i, addr_i, `SBF_OFS_DATA_LOW);
  assign ctrl1_wr  = hit(wr_i, addr_i, `SBF_OFS_CTRL1);
  assign baud_wr   = hit(wr_i, addr_i, `SBF_OFS_BAUD);
  assign is_master = ctrl1[`SBF_CTRL1_ENABLE] && ctrl1[`SBF_CTRL1_MASTER];
  assign half      = half_of(baud);

  // ------------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctrl1     <= `SBF_RST_CTRL1;
      ctrl2     <= `SBF_RST_CTRL2;
      baud      <= sbf_baud_t'(6'h00);
      data_high <= 8'h00;
    end else if (wr_i) begin
      case (addr_i)
        `SBF_OFS_CTRL1:     ctrl1 <= wdata_i;
        `SBF_OFS_CTRL2:     ctrl2 <= wdata_i;
        `SBF_OFS_BAUD: begin
          baud.prescale <= wdata_i[`SBF_BAUD_PRE_LSB +: 3];
          baud.rate_sel <= wdata_i[`SBF_BAUD_SEL_LSB +: 3];
        end
        `SBF_OFS_DATA_HIGH: data_high <= wdata_i;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Read port, data one cycle after the strobe
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `SBF_OFS_CTRL1:     rdata_o <= ctrl1;
        `SBF_OFS_CTRL2:     rdata_o <= ctrl2;
        `SBF_OFS_BAUD:      rdata_o <= {1'b0, baud.prescale, 1'b0,
                                        baud.rate_sel};
        `SBF_OFS_FLAGS:     rdata_o <= {flags.rx_done, 1'b0, flags.tx_empty,
                                        flags.mode_fault, 4'h0};
        `SBF_OFS_DATA_HIGH: rdata_o <= data_high;
        `SBF_OFS_DATA_LOW:  rdata_o <= rx_data;
        default:            rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------------
  assign mf_set  = is_master && ctrl2[`SBF_CTRL2_MFDEN] && !ss_b_i;
  assign tx_push = low_wr && tx_arm && flags.tx_empty && buf_ready;
  assign rx_set  = done;

  // Set wins over clear in every flag
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      flags.rx_done <= 1'b0;
    end else if (rx_set) begin
      flags.rx_done <= 1'b1;
    end else if (low_rd && rx_arm) begin
      flags.rx_done <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      flags.tx_empty <= `SBF_RST_TX_EMPTY;
    end else if (!flags.tx_empty && buf_ready) begin
      flags.tx_empty <= 1'b1;
    end else if (tx_push) begin
      flags.tx_empty <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      flags.mode_fault <= 1'b0;
    end else if (mf_set) begin
      flags.mode_fault <= 1'b1;
    end else if (ctrl1_wr && mf_arm) begin
      flags.mode_fault <= 1'b0;
    end
  end

  // Arming: a status read that saw the flag set enables its clear
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rx_arm <= 1'b0;
      tx_arm <= 1'b0;
      mf_arm <= 1'b0;
    end else begin
      if (status_rd && flags.rx_done) begin
        rx_arm <= 1'b1;
      end else if (low_rd || !flags.rx_done) begin
        rx_arm <= 1'b0;
      end
      if (status_rd && flags.tx_empty) begin
        tx_arm <= 1'b1;
      end else if (low_wr || !flags.tx_empty) begin
        tx_arm <= 1'b0;
      end
      if (status_rd && flags.mode_fault) begin
        mf_arm <= 1'b1;
      end else if (ctrl1_wr || !flags.mode_fault) begin
        mf_arm <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Transmit buffer between the register port and the shifter
  // ------------------------------------------------------------------
  sbf_buf2 #(
    .WIDTH (8)
  ) u_txbuf (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (tx_push),
    .in_ready_o  (buf_ready),
    .in_data_i   (wdata_i),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_pop),
    .out_data_o  (buf_data)
  );

  // ------------------------------------------------------------------
  // Rate generator and master shifter
  // ------------------------------------------------------------------
  // Rate changes and faults abort a frame rather than stretch it
  assign abort   = baud_wr || mf_set || !is_master || flags.mode_fault;
  assign buf_pop = (state == SBF_IDLE) && !abort && buf_valid;
  assign toggle  = (state == SBF_SHIFT) && !abort &&
                   (half_cnt == half - 11'h001);
  assign done    = toggle && sck_q && (bit_cnt == `SBF_BITS);
  assign mosi_o  = shreg[7];
  assign sck_o   = sck_q;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state <= SBF_IDLE;
    end else begin
      case (state)
        SBF_IDLE:  if (buf_pop) begin
          state <= SBF_SHIFT;
        end
        SBF_SHIFT: if (abort || done) begin
          state <= SBF_IDLE;
        end
        default:   state <= SBF_IDLE;
      endcase
    end
  end

  // Full serial period spans the whole divisor of bus cycles
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      half_cnt <= 11'h000;
      sck_q    <= 1'b0;
    end else if (state != SBF_SHIFT || abort) begin
      half_cnt <= 11'h000;
      sck_q    <= 1'b0;
    end else if (toggle) begin
      half_cnt <= 11'h000;
      sck_q    <= ~sck_q;
    end else begin
      half_cnt <= half_cnt + 11'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      shreg   <= 8'h00;
      sample  <= 1'b0;
      bit_cnt <= 3'h0;
    end else if (buf_pop) begin
      shreg   <= buf_data;
      bit_cnt <= 3'h0;
    end else if (toggle && !sck_q) begin
      sample  <= miso_i;
    end else if (toggle) begin
      shreg   <= {shreg[6:0], sample};
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // New byte only lands while the old one has been taken
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rx_data <= 8'h00;
    end else if (done && (!flags.rx_done || (low_rd && rx_arm))) begin
      rx_data <= {shreg[6:0], sample};
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  logic [10:0] gap;
  logic        last_sck;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || state != SBF_SHIFT) begin
      gap <= 11'h000;
    end else if (sck_q != last_sck) begin
      gap <= 11'h001;
    end else begin
      gap <= gap + 11'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    last_sck <= sck_q;
  end

  sequence seq_flagged_rx_read;
    rx_arm && low_rd && !rx_set;
  endsequence

  sequence seq_flagged_mf_write;
    mf_arm && ctrl1_wr && !mf_set;
  endsequence

  chk_half_period: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (state == SBF_SHIFT && sck_q != last_sck && gap != 11'h000 &&
     !$past(baud_wr)) |-> (gap == half))
    else $error("serial clock half period wrong");
  chk_divisor_range: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    ({half, 1'b0} >= 12'h002) && ({half, 1'b0} <= 12'h800))
    else $error("divisor outside 2..2048");
  chk_rx_bit_read: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    status_rd |=> (rdata_o[`SBF_FLAG_RX] == $past(flags.rx_done)))
    else $error("receive flag misreported");
  chk_status_zeros: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    status_rd |=> (rdata_o[6] == 1'b0 && rdata_o[3:0] == 4'h0))
    else $error("unimplemented status bits not zero");
  chk_tx_after_reset: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(rst_b_i) |-> flags.tx_empty)
    else $error("transmit flag not one after reset");
  chk_mode_fault_flag_set: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    mf_set |=> flags.mode_fault && (state == SBF_IDLE))
    else $error("mode fault not flagged");
  chk_mode_fault_flag_clear: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    seq_flagged_mf_write |=> !flags.mode_fault)
    else $error("mode fault not cleared");
  chk_rx_clear: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    seq_flagged_rx_read |=> !flags.rx_done)
    else $error("receive flag not cleared");
  chk_rx_high_read: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (flags.rx_done && hit(rd_i, addr_i, `SBF_OFS_DATA_HIGH)) |=>
    flags.rx_done)
    else $error("high byte read touched receive flag");
  chk_tx_ignore: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (low_wr && !flags.tx_empty) |=> $stable(u_txbuf.wr_ptr))
    else $error("write accepted while register full");
  // Flag comes back only once the buffer has room again
  chk_tx_clear: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    tx_push |=> !flags.tx_empty ##1 (flags.tx_empty == $past(buf_ready)))
    else $error("transmit flag sequence wrong");
  chk_status_ro: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    hit(wr_i, addr_i, `SBF_OFS_FLAGS) |=> $stable(ctrl1) && $stable(ctrl2))
    else $error("status write had an effect");

endmodule // sbf_top

// *** spi_baud_and_status_flags_tb.sv ***
// Self-checking bench for the serial rate generator and status flags.
// Assumes the register index map and flag layout of the defs header.
`timescale 1ns/1ps
`include "sbf_defs.svh"
`define CHK_EQ(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end
module spi_baud_and_status_flags_tb;
  logic       clk_i;
  logic       rst_b_i;
  logic [2:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic       ss_b_i;
  logic       miso_i;
  logic       sck_o;
  logic       mosi_o;
  logic [7:0] reply;
  logic [7:0] got;
  logic [7:0] frames;
  logic [7:0] v;
  int         fails;
  int         checks;

  sbf_top i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ss_b_i(ss_b_i), .miso_i(miso_i), .sck_o(sck_o), .mosi_o(mosi_o));

  sbf_slave_model i_peer (.clk_i(clk_i), .rst_b_i(rst_b_i), .sck_i(sck_o),
    .mosi_i(mosi_o), .miso_o(miso_i), .reply_i(reply), .got_o(got),
    .frames_o(frames));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // --------------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------------
  task automatic end_of_test();
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic reset();
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK_EQ(d, e)
  endtask

  task automatic step();
    @(posedge clk_i);
    #1;
  endtask

  task automatic wait_sck(input logic lv, output int n);
    n = 0;
    #1;
    while (sck_o !== lv) begin
      step();
      n++;
      if (n > 5000) begin
        fails++;
        end_of_test();
      end
    end
  endtask

  task automatic pulse_ss();
    @(posedge clk_i);
    ss_b_i <= 1'b0;
    @(posedge clk_i);
    ss_b_i <= 1'b1;
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  initial begin
    int         n;
    int         hi;
    int         lo;
    int         dv;
    logic [2:0] pre_t [6];
    logic [2:0] sel_t [6];
    pre_t = '{3'h0, 3'h0, 3'h2, 3'h4, 3'h7, 3'h5};
    sel_t = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7, 3'h0};
    fails = 0;
    checks = 0;
    rst_b_i = 1'b0;
    addr_i = 3'h0;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    ss_b_i = 1'b1;
    reply = 8'hA5;
    reset();
    rdc(`SBF_OFS_FLAGS, 8'h20);
    rdc(`SBF_OFS_BAUD, 8'h00);
    wr(`SBF_OFS_FLAGS, 8'hFF);
    rdc(`SBF_OFS_FLAGS, 8'h20);
    rdc(3'h6, 8'h00);
    wr(`SBF_OFS_DATA_HIGH, 8'h5A);
    rdc(`SBF_OFS_DATA_HIGH, 8'h5A);
    // Reset drops the arming left by the status reads above
    reset();
    // Write to data low without a flagged status read first
    wr(`SBF_OFS_CTRL1, 8'h50);
    wr(`SBF_OFS_DATA_LOW, 8'h11);
    wait_sck(1'b0, n);
    hi = 0;
    repeat (20) begin
      step();
      if (sck_o !== 1'b0) hi++;
    end
    `CHK_EQ(hi, 0)
    rdc(`SBF_OFS_FLAGS, 8'h20);
    // Divisor per field pair; a new baud write aborts the frame
    for (int i = 0; i < 6; i++) begin
      dv = (int'(pre_t[i]) + 1) << (int'(sel_t[i]) + 1);
      wr(`SBF_OFS_BAUD, {1'b0, pre_t[i], 1'b0, sel_t[i]});
      rdc(`SBF_OFS_BAUD, {1'b0, pre_t[i], 1'b0, sel_t[i]});
      rd(`SBF_OFS_FLAGS, v);
      wr(`SBF_OFS_DATA_LOW, 8'h96);
      wait_sck(1'b1, n);
      wait_sck(1'b0, hi);
      wait_sck(1'b1, lo);
      `CHK_EQ(hi, dv / 2)
      `CHK_EQ(hi + lo, dv)
    end
    // Whole frame and the receive-flag clearing sequence
    reset();
    wr(`SBF_OFS_CTRL1, 8'h50);
    rd(`SBF_OFS_FLAGS, v);
    wr(`SBF_OFS_DATA_LOW, 8'h3C);
    n = 0;
    v = 8'h00;
    while (v[7] !== 1'b1) begin
      rd(`SBF_OFS_FLAGS, v);
      n++;
      if (n > 100) begin
        fails++;
        end_of_test();
      end
    end
    `CHK_EQ(v, 8'hA0)
    `CHK_EQ(got, 8'h3C)
    rd(`SBF_OFS_DATA_HIGH, v);
    rdc(`SBF_OFS_FLAGS, 8'hA0);
    rdc(`SBF_OFS_DATA_LOW, 8'hA5);
    rdc(`SBF_OFS_FLAGS, 8'h20);
    // Fill the buffer while a slow frame runs; three words go out, the write while full is dropped
    reset();
    wr(`SBF_OFS_CTRL1, 8'h50);
    wr(`SBF_OFS_BAUD, 8'h01);
    for (int i = 1; i <= 3; i++) begin
      rd(`SBF_OFS_FLAGS, v);
      wr(`SBF_OFS_DATA_LOW, 8'(i * 8'h11));
    end
    rdc(`SBF_OFS_FLAGS, 8'h00);
    wr(`SBF_OFS_DATA_LOW, 8'h44);
    n = 0;
    while (frames !== 8'h03) begin
      step();
      n++;
      if (n > 500) begin
        fails++;
        end_of_test();
      end
    end
    `CHK_EQ(got, 8'h33)
    repeat (60) step();
    `CHK_EQ(frames, 8'h03)
    // Mode fault: detection off, then on, then the clearing sequence
    reset();
    wr(`SBF_OFS_CTRL1, 8'h50);
    pulse_ss();
    rdc(`SBF_OFS_FLAGS, 8'h20);
    wr(`SBF_OFS_CTRL2, 8'h10);
    pulse_ss();
    wr(`SBF_OFS_CTRL1, 8'h50);
    rdc(`SBF_OFS_FLAGS, 8'h30);
    wr(`SBF_OFS_CTRL1, 8'h50);
    rdc(`SBF_OFS_FLAGS, 8'h20);
    end_of_test();
  end
endmodule // spi_baud_and_status_flags_tb
